// ==== rtl/phy_misc_pkg.sv ====
// shared constants, field layouts and types of the lamp, reset and power-down block
package phy_misc_pkg;
    // clocking and derived counts
    localparam int CLK_HZ         = 100_000_000;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int MII_REF_HZ     = 25_000_000;
    localparam int RMII_REF_HZ    = 50_000_000;
    localparam int MII_HALF_CYC   = CLK_HZ / (2 * MII_REF_HZ);
    localparam int RMII_HALF_CYC  = CLK_HZ / (2 * RMII_REF_HZ);
    localparam int RESET_MIN_NS   = 1000;
    localparam int RESET_MIN_CYC  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CYC       = RESET_MIN_CYC;
    localparam int BLINK_HALF_MS  = 50;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_EVT  = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;
    // control fields
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_DUP_BIT   = 2;
    localparam int CTRL_IRQFN_BIT = 3;
    localparam int CTRL_IRQEN_BIT = 4;
    // status fields
    localparam int STAT_LINK_BIT  = 0;
    localparam int STAT_SPEED_BIT = 1;
    localparam int STAT_DUP_BIT   = 2;
    localparam int STAT_RMII_BIT  = 3;
    localparam int STAT_AN0_BIT   = 4;
    localparam int STAT_AN1_BIT   = 5;
    localparam int STAT_ANEN_BIT  = 6;
    localparam int STAT_PD_BIT    = 7;
    // event fields
    localparam int EVT_W         = 4;
    localparam int EVT_LINK_BIT  = 0;
    localparam int EVT_SPEED_BIT = 1;
    localparam int EVT_COL_BIT   = 2;
    localparam int EVT_DUP_BIT   = 3;
    localparam logic LAMP_ON     = 1'b1;

    typedef enum logic [1:0] {
        MODE_RSVD = 2'b00,
        MODE_1    = 2'b01,
        MODE_2    = 2'b10,
        MODE_3    = 2'b11
    } lamp_mode_e;

    typedef enum logic [1:0] {
        PH_STRAP = 2'b00,
        PH_INIT  = 2'b01,
        PH_RUN   = 2'b10
    } phase_e;

    typedef struct packed {
        logic link;
        logic rate;
        logic act;
    } lamp_s;

    typedef struct packed {
        logic an_en;
        logic an1;
        logic an0;
        logic rmii;
    } strap_s;

    typedef struct packed {
        lamp_mode_e       mode;
        logic             dup_sel;
        logic             irq_fn;
        logic             irq_en;
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] mask;
        strap_s           strap;
        phase_e           phase;
        logic [15:0]      init_cnt;
        logic [1:0]       div_cnt;
        logic             clk_out;
        lamp_s            lamp;
        logic             lamp_oe;
        logic             power_down;
        logic             resp;
        logic [31:0]      rdata;
        logic             link_d;
        logic             speed_d;
        logic             dup_d;
    } state_s;

    localparam state_s STATE_RST = '{mode: MODE_1, dup_sel: 1'b0, irq_fn: 1'b0, irq_en: 1'b0,
        evt: 4'h0, mask: 4'h0, strap: 4'h0, phase: PH_STRAP, init_cnt: 16'h0000,
        div_cnt: 2'h0, clk_out: 1'b0, lamp: 3'h0, lamp_oe: 1'b0, power_down: 1'b0,
        resp: 1'b0, rdata: 32'h00000000, link_d: 1'b0, speed_d: 1'b0, dup_d: 1'b0};
endpackage

// ==== rtl/lamp_blinker.sv ====
// free-running blink phase generator for the link lamp
`timescale 1ns/1ps
module lamp_blinker #(
    parameter int HALF_CYC = 5_000_000
) (
    input  logic ref_clk_i,  // system clock
    input  logic rst_n_i,    // synchronous reset, active low
    output logic phase_o     // blink phase, toggles every half period
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        phase;
    } blink_s;

    blink_s st_r;
    blink_s st_nxt;

    // count one half period, then flip the phase
    always_comb begin
        st_nxt = st_r;
        if (st_r.cnt == 32'(HALF_CYC - 1)) begin
            st_nxt.cnt   = 32'h00000000;
            st_nxt.phase = ~st_r.phase;
        end else begin
            st_nxt.cnt = st_r.cnt + 32'h00000001;
        end
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign phase_o = st_r.phase;

    a_blink_period: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $changed(phase_o) |-> $past(st_r.cnt) == 32'(HALF_CYC - 1))
        else $error("blink phase changed before half period elapsed");
endmodule

// ==== rtl/test_reset_ctrl.sv ====
// asynchronous test-logic reset with synchronised release
`timescale 1ns/1ps
module test_reset_ctrl (
    input  logic ref_clk_i,         // system clock
    input  logic test_rst_n_i,      // test reset, active low, asynchronous
    output logic test_logic_reset_o // test access logic held in reset
);
    logic hold1_r;
    logic hold2_r;

    // assert at once without any clock, release two edges later
    always_ff @(posedge ref_clk_i or negedge test_rst_n_i) begin
        if (!test_rst_n_i) begin
            hold1_r <= 1'b1;
            hold2_r <= 1'b1;
        end else begin
            hold1_r <= 1'b0;
            hold2_r <= hold1_r;
        end
    end

    assign test_logic_reset_o = hold2_r;

    a_test_reset_hold: assert property (@(posedge ref_clk_i)
        !test_rst_n_i |-> test_logic_reset_o)
        else $error("test reset low but test logic not in reset");
    a_test_reset_free: assert property (@(posedge ref_clk_i)
        test_rst_n_i [*3] |-> !test_logic_reset_o)
        else $error("test logic reset not released");
endmodule

// ==== rtl/phy_led_reset_powerdown_ctrl.sv ====
// reference clock out, status lamps, reset/strap handling and power-down/irq pin
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module phy_led_reset_powerdown_ctrl #(
    parameter int BLINK_HALF_CYC = phy_misc_pkg::BLINK_HALF_CYC
) (
    input  logic                 ref_clk_i,          // 100 MHz system clock
    input  logic                 rst_n_i,            // hardware reset, active low
    input  logic                 test_rst_n_i,       // test reset, active low, async
    output logic                 test_logic_reset_o, // test logic held in reset
    // avalon-mm slave
    input  logic [7:0]           address_i,          // byte address
    input  logic                 read_i,             // read request
    input  logic                 write_i,            // write request
    input  logic [31:0]          writedata_i,        // write data
    input  logic [3:0]           byteenable_i,       // byte lanes
    output logic [31:0]          readdata_o,         // read data
    output logic                 waitrequest_o,      // stall
    output logic                 irq_o,              // level interrupt
    // line status from the transceiver core
    input  logic                 link_good_i,        // link up
    input  logic                 speed100_i,         // 100 Mb/s
    input  logic                 full_duplex_i,      // full duplex
    input  logic                 tx_active_i,        // transmit activity
    input  logic                 rx_active_i,        // receive activity
    input  logic                 collision_i,        // collision seen
    input  logic                 rmii_strap_i,       // interface strap level
    // pins
    output logic                 ref_clk_out_o,      // reference clock out
    input  phy_misc_pkg::lamp_s  lamp_pin_i,         // lamp pin levels (straps)
    output phy_misc_pkg::lamp_s  lamp_pin_o,         // lamp drive
    output phy_misc_pkg::lamp_s  lamp_pin_oe_o,      // lamp output enables
    input  logic                 sleep_pin_i,        // shared pin level
    output logic                 sleep_pin_o,        // shared pin drive
    output logic                 sleep_pin_oe_o,     // shared pin pull-down enable
    // results
    output phy_misc_pkg::strap_s strap_cfg_o,        // latched straps
    output logic                 power_down_o,       // power-down mode
    output logic                 ready_o             // initialisation done
);
    import phy_misc_pkg::*;

    localparam int INIT_LEN = INIT_CYC;

    state_s st_r;
    state_s st_nxt;
    logic   blink_phase;
    logic   bus_req;
    logic   wr_take;
    logic   act_any;

    // blink phase source
    lamp_blinker #(
        .HALF_CYC (BLINK_HALF_CYC)
    ) u_blink (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .phase_o   (blink_phase)
    );

    // test access reset
    test_reset_ctrl u_test_rst (
        .ref_clk_i          (ref_clk_i),
        .test_rst_n_i       (test_rst_n_i),
        .test_logic_reset_o (test_logic_reset_o)
    );

    // register read mux, unmapped words read as zero
    function automatic logic [31:0] reg_read(input state_s s, input logic [7:0] addr,
                                             input logic lk, input logic sp, input logic dp);
        logic [31:0] v;
        v = 32'h00000000;
        case (addr)
            OFF_CTRL: begin
                v[CTRL_MODE_LSB +: 2] = s.mode;
                v[CTRL_DUP_BIT]       = s.dup_sel;
                v[CTRL_IRQFN_BIT]     = s.irq_fn;
                v[CTRL_IRQEN_BIT]     = s.irq_en;
            end
            OFF_STAT: begin
                v[STAT_LINK_BIT]  = lk;
                v[STAT_SPEED_BIT] = sp;
                v[STAT_DUP_BIT]   = dp;
                v[STAT_RMII_BIT]  = s.strap.rmii;
                v[STAT_AN0_BIT]   = s.strap.an0;
                v[STAT_AN1_BIT]   = s.strap.an1;
                v[STAT_ANEN_BIT]  = s.strap.an_en;
                v[STAT_PD_BIT]    = s.power_down;
            end
            OFF_EVT:  v[EVT_W-1:0] = s.evt;
            OFF_MASK: v[EVT_W-1:0] = s.mask;
            default:  v = 32'h00000000;
        endcase
        return v;
    endfunction

    // bus handshake: one wait cycle, write lands when waitrequest is low
    assign bus_req = read_i | write_i;
    assign wr_take = write_i & st_r.resp;
    assign act_any = tx_active_i | rx_active_i;

    // next-state logic
    always_comb begin
        logic [EVT_W-1:0] ev_set;
        logic [EVT_W-1:0] ev_clr;
        logic             half_hit;
        ev_set   = '0;
        ev_clr   = '0;
        half_hit = 1'b0;
        st_nxt   = st_r;

        // reset-release sequence: catch straps, then count the init period
        unique case (st_r.phase)
            PH_STRAP: begin
                st_nxt.strap.an_en = lamp_pin_i.act;
                st_nxt.strap.an1   = lamp_pin_i.rate;
                st_nxt.strap.an0   = lamp_pin_i.link;
                st_nxt.strap.rmii  = rmii_strap_i;
                st_nxt.lamp_oe     = 1'b1;
                st_nxt.phase       = PH_INIT;
            end
            PH_INIT: begin
                if (st_r.init_cnt == 16'(INIT_LEN - 1)) begin
                    st_nxt.phase = PH_RUN;
                end else begin
                    st_nxt.init_cnt = st_r.init_cnt + 16'h0001;
                end
            end
            PH_RUN: st_nxt.phase = PH_RUN;
            default: st_nxt.phase = PH_STRAP;
        endcase

        // reference clock divider, rate chosen by the interface strap
        if (st_r.strap.rmii) begin
            half_hit = (st_r.div_cnt >= 2'(RMII_HALF_CYC - 1));
        end else begin
            half_hit = (st_r.div_cnt >= 2'(MII_HALF_CYC - 1));
        end
        if (st_r.phase == PH_RUN && half_hit) begin
            st_nxt.div_cnt = 2'h0;
            st_nxt.clk_out = ~st_r.clk_out;
        end else if (st_r.phase == PH_RUN) begin
            st_nxt.div_cnt = st_r.div_cnt + 2'h1;
        end

        // lamps
        st_nxt.lamp.rate = speed100_i ? LAMP_ON : ~LAMP_ON;
        unique case (st_r.mode)
            MODE_2, MODE_3: begin
                st_nxt.lamp.link = (link_good_i && !(act_any && blink_phase)) ?
                                   LAMP_ON : ~LAMP_ON;
                if (st_r.mode == MODE_3 && st_r.dup_sel) begin
                    st_nxt.lamp.act = full_duplex_i ? LAMP_ON : ~LAMP_ON;
                end else begin
                    st_nxt.lamp.act = collision_i ? LAMP_ON : ~LAMP_ON;
                end
            end
            default: begin
                st_nxt.lamp.link = link_good_i ? LAMP_ON : ~LAMP_ON;
                st_nxt.lamp.act  = act_any ? LAMP_ON : ~LAMP_ON;
            end
        endcase

        // power-down request from the shared pin while it is an input
        st_nxt.power_down = (st_r.phase == PH_RUN) && !st_r.irq_fn && !sleep_pin_i;

        // line events
        st_nxt.link_d  = link_good_i;
        st_nxt.speed_d = speed100_i;
        st_nxt.dup_d   = full_duplex_i;
        if (st_r.phase == PH_RUN) begin
            ev_set[EVT_LINK_BIT]  = link_good_i ^ st_r.link_d;
            ev_set[EVT_SPEED_BIT] = speed100_i ^ st_r.speed_d;
            ev_set[EVT_COL_BIT]   = collision_i;
            ev_set[EVT_DUP_BIT]   = full_duplex_i ^ st_r.dup_d;
        end

        // bus answer: data captured one edge after the request is seen
        if (bus_req && !st_r.resp && st_r.phase == PH_RUN) begin
            st_nxt.resp  = 1'b1;
            st_nxt.rdata = read_i ? reg_read(st_r, address_i, link_good_i, speed100_i,
                                             full_duplex_i) : 32'h00000000;
        end else begin
            st_nxt.resp = 1'b0;
        end

        // register writes
        if (wr_take && byteenable_i[0]) begin
            unique case (address_i)
                OFF_CTRL: begin
                    st_nxt.mode    = lamp_mode_e'(writedata_i[CTRL_MODE_LSB +: 2]);
                    st_nxt.dup_sel = writedata_i[CTRL_DUP_BIT];
                    st_nxt.irq_fn  = writedata_i[CTRL_IRQFN_BIT];
                    st_nxt.irq_en  = writedata_i[CTRL_IRQEN_BIT];
                end
                OFF_EVT:  ev_clr = writedata_i[EVT_W-1:0];
                OFF_MASK: st_nxt.mask = writedata_i[EVT_W-1:0];
                default:  ev_clr = '0;
            endcase
        end

        // sticky events, a new event wins over a clear
        st_nxt.evt = (st_r.evt & ~ev_clr) | ev_set;
    end

    // state register; every field takes its default on reset
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_r <= STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign readdata_o     = st_r.rdata;
    assign waitrequest_o  = bus_req & ~st_r.resp;
    assign irq_o          = |(st_r.evt & st_r.mask);
    assign ref_clk_out_o  = st_r.clk_out;
    assign lamp_pin_o     = st_r.lamp;
    assign lamp_pin_oe_o  = {3{st_r.lamp_oe}};
    assign strap_cfg_o    = st_r.strap;
    assign power_down_o   = st_r.power_down;
    assign ready_o        = (st_r.phase == PH_RUN);
    // open drain: only ever drive low, enable while an irq is pending with irq_fn and irq_en both set
    assign sleep_pin_o    = 1'b0;
    assign sleep_pin_oe_o = st_r.irq_fn & st_r.irq_en & irq_o;

    // cycles since reset release, for the init-length check
    logic [15:0] rel_cnt_r;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rel_cnt_r <= 16'h0000;
        end else if (!ready_o) begin
            rel_cnt_r <= rel_cnt_r + 16'h0001;
        end
    end

    sequence s_edge;
        $changed(ref_clk_out_o);
    endsequence
    sequence s_hold_then_edge;
        !$changed(ref_clk_out_o) ##1 $changed(ref_clk_out_o);
    endsequence

    a_clk_mii_rate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ready_o && $past(ready_o) && !strap_cfg_o.rmii) ##0 s_edge |=> s_hold_then_edge)
        else $error("reference clock out not at MII rate");
    a_clk_rmii_rate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ready_o && $past(ready_o) && strap_cfg_o.rmii) |=> s_edge)
        else $error("reference clock out not at RMII rate");
    a_link_mode_one: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        st_r.mode == MODE_1 |=> lamp_pin_o.link == ($past(link_good_i) ? LAMP_ON : ~LAMP_ON))
        else $error("link lamp does not follow link in mode 1");
    a_link_blink_on: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (st_r.mode inside {MODE_2, MODE_3}) |=>
        lamp_pin_o.link == (($past(link_good_i) && !($past(act_any) && $past(blink_phase)))
                            ? LAMP_ON : ~LAMP_ON))
        else $error("link lamp blink wrong in modes 2 and 3");
    a_rate_lamp: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        1'b1 |=> lamp_pin_o.rate == ($past(speed100_i) ? LAMP_ON : ~LAMP_ON))
        else $error("rate lamp does not follow speed");
    a_act_mode_one: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (st_r.mode == MODE_1 && act_any) |=> lamp_pin_o.act == LAMP_ON)
        else $error("activity lamp off during activity in mode 1");
    a_col_mode_two: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        st_r.mode == MODE_2 |=> lamp_pin_o.act == ($past(collision_i) ? LAMP_ON : ~LAMP_ON))
        else $error("collision lamp wrong in mode 2");
    a_dup_mode_three: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (st_r.mode == MODE_3 && st_r.dup_sel) |=>
        lamp_pin_o.act == ($past(full_duplex_i) ? LAMP_ON : ~LAMP_ON))
        else $error("duplex lamp wrong in mode 3");
    a_init_length: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(ready_o) |-> rel_cnt_r > 16'(INIT_LEN))
        else $error("initialisation shorter than its period");
    a_reset_defaults: assert property (@(posedge ref_clk_i)
        !rst_n_i |=> st_r.mode == MODE_1 && st_r.mask == '0 && st_r.evt == '0 && !ready_o)
        else $error("registers not at defaults after reset");
    a_pin_default_pd: assert property (@(posedge ref_clk_i)
        !rst_n_i |=> !st_r.irq_fn && !sleep_pin_oe_o)
        else $error("shared pin not in power-down function after reset");
    a_strap_capture: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(rst_n_i) |=> strap_cfg_o == {$past(lamp_pin_i.act), $past(lamp_pin_i.rate),
                                           $past(lamp_pin_i.link), $past(rmii_strap_i)})
        else $error("straps not taken at reset release");
    a_pd_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ready_o && !st_r.irq_fn && !sleep_pin_i) |=> power_down_o)
        else $error("power-down not entered on low pin");
    a_irq_pull: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (st_r.irq_fn && st_r.irq_en && irq_o) |-> sleep_pin_oe_o && !sleep_pin_o)
        else $error("pending irq not pulled onto shared pin");
    a_irq_release: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !irq_o |-> !sleep_pin_oe_o)
        else $error("shared pin driven with no pending irq");

    // init and pin checks: bus stalled and clock quiet until initialisation ends;
    // lamp pins float in reset so the strap resistors can be read

    a_bus_stall_init: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (!ready_o && bus_req) |-> waitrequest_o)
        else $error("bus answered during initialisation");

    a_clk_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !ready_o |-> !ref_clk_out_o)
        else $error("reference clock out running before ready");

    a_oe_in_reset: assert property (@(posedge ref_clk_i)
        !rst_n_i |=> lamp_pin_oe_o == 3'b000)
        else $error("lamp pins driven during reset");

    a_oe_after_init: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ready_o |-> lamp_pin_oe_o == 3'b111)
        else $error("lamp pins not driven after initialisation");

    a_pd_leave: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ready_o && sleep_pin_i) |=> !power_down_o)
        else $error("power-down kept with pin high");

    a_pd_off_irq: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        st_r.irq_fn |=> !power_down_o)
        else $error("power-down taken while pin is an interrupt");

    a_evt_col_set: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (ready_o && collision_i) |=> st_r.evt[EVT_COL_BIT])
        else $error("collision event not latched");
endmodule

// ==== verification/phy_far_side.sv ====
// far-side model: reset source, strap resistors, lamp pins and pulled-up shared pin
`timescale 1ns/1ps
module phy_far_side (
    input  logic                ref_clk_i,   // system clock
    input  logic                rst_req_i,   // start a reset pulse
    output logic                rst_n_o,     // hardware reset, active low
    input  phy_misc_pkg::lamp_s strap_lvl_i, // strap resistor levels
    input  phy_misc_pkg::lamp_s lamp_drv_i,  // lamp drive from device
    input  phy_misc_pkg::lamp_s lamp_oe_i,   // lamp enables
    output phy_misc_pkg::lamp_s lamp_lvl_o,  // lamp pin levels
    input  logic                pd_req_i,    // controller asks power-down
    input  logic                sleep_oe_i,  // device pulls shared pin low
    output logic                sleep_lvl_o  // shared pin level
);
    import phy_misc_pkg::*;
    logic [7:0] hold_cnt_r = 8'(RESET_MIN_CYC);
    // each request holds reset low for the full minimum time
    always @(posedge ref_clk_i) begin
        if (rst_req_i)
            hold_cnt_r <= 8'(RESET_MIN_CYC);
        else if (hold_cnt_r != 8'h00)
            hold_cnt_r <= hold_cnt_r - 8'h01;
    end
    assign rst_n_o = (hold_cnt_r == 8'h00);
    // strap resistors show through while the device is not driving
    assign lamp_lvl_o = (lamp_oe_i & lamp_drv_i) | (~lamp_oe_i & strap_lvl_i);
    // pull-up unless the controller or the device pulls low
    assign sleep_lvl_o = !(pd_req_i || sleep_oe_i);
endmodule

// ==== verification/test_phy_led_reset_powerdown_ctrl.sv ====
// self-checking bench of the lamp, reset and power-down block
`timescale 1ns/1ps
module test_phy_led_reset_powerdown_ctrl;
    import phy_misc_pkg::*;
    logic ref_clk_i = 1'b0, test_rst_n_i = 1'b1, read_i = 1'b0, write_i = 1'b0;
    logic rst_n_i, rst_req = 1'b0, pd_req = 1'b0, link_good_i = 1'b0, speed100_i = 1'b0;
    logic full_duplex_i = 1'b0, tx_active_i = 1'b0, rx_active_i = 1'b0, collision_i = 1'b0;
    logic rmii_strap_i = 1'b0, waitrequest_o, irq_o, ref_clk_out_o, sleep_pin_i, sleep_pin_o;
    logic sleep_pin_oe_o, power_down_o, ready_o, test_logic_reset_o;
    logic [7:0]  address_i = 8'h00;
    logic [31:0] writedata_i = 32'h0, readdata_o, q;
    lamp_s       lamp_pin_i, lamp_pin_o, lamp_pin_oe_o, strap_lvl = 3'b101;
    strap_s      strap_cfg_o;
    int          err_total = 0, checks_done = 0;

    // 100 MHz clock
    always #5 ref_clk_i = ~ref_clk_i;

    phy_led_reset_powerdown_ctrl #(.BLINK_HALF_CYC(4)) phy_led_reset_powerdown_ctrl_i (
        .ref_clk_i, .rst_n_i, .test_rst_n_i, .test_logic_reset_o, .address_i, .read_i,
        .write_i, .writedata_i, .byteenable_i(4'hF), .readdata_o, .waitrequest_o, .irq_o,
        .link_good_i, .speed100_i, .full_duplex_i, .tx_active_i, .rx_active_i, .collision_i,
        .rmii_strap_i, .ref_clk_out_o, .lamp_pin_i, .lamp_pin_o, .lamp_pin_oe_o, .sleep_pin_i,
        .sleep_pin_o, .sleep_pin_oe_o, .strap_cfg_o, .power_down_o, .ready_o);
    phy_far_side phy_far_side_i (.ref_clk_i, .rst_req_i(rst_req), .rst_n_o(rst_n_i),
        .strap_lvl_i(strap_lvl), .lamp_drv_i(lamp_pin_o), .lamp_oe_i(lamp_pin_oe_o),
        .lamp_lvl_o(lamp_pin_i), .pd_req_i(pd_req), .sleep_oe_i(sleep_pin_oe_o),
        .sleep_lvl_o(sleep_pin_i));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        read_i <= !we;
        write_i <= we;
        address_i <= a;
        writedata_i <= d;
        for (n = 0; n < 300; n++) begin
            @(posedge ref_clk_i);
            if (waitrequest_o === 1'b0)
                break;
        end
        q = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        if (n == 300) begin
            err_total++;
            stop_test();
        end
    endtask
    // straps, defaults and clock-out rate after a reset
    task automatic t_reset(input strap_s s, input int half);
        int n;
        int tg = 0;
        logic prev;
        for (n = 0; n < 400 && ready_o !== 1'b1; n++)
            cyc(1);
        if (n == 400) begin
            err_total++;
            stop_test();
        end
        chk(strap_cfg_o, s);
        chk(sleep_pin_oe_o, 1'b0);
        chk(lamp_pin_oe_o, 3'b111);
        bus(1'b0, OFF_CTRL, 32'h0);
        chk(q[7:0], 8'h01);
        prev = ref_clk_out_o;
        repeat (8) begin
            cyc(1);
            tg += int'(ref_clk_out_o !== prev);
            prev = ref_clk_out_o;
        end
        chk(tg, 8 / half);
    endtask
    task automatic t_mode1();
        link_good_i <= 1'b1;
        speed100_i <= 1'b1;
        tx_active_i <= 1'b1;
        cyc(2);
        chk(lamp_pin_o, 3'b111);
        link_good_i <= 1'b0;
        speed100_i <= 1'b0;
        tx_active_i <= 1'b0;
        rx_active_i <= 1'b1;
        cyc(2);
        chk(lamp_pin_o, 3'b001);
        rx_active_i <= 1'b0;
    endtask
    task automatic t_mode2();
        int on = 0;
        int off = 0;
        bus(1'b1, OFF_CTRL, 32'h2);
        collision_i <= 1'b1;
        link_good_i <= 1'b1;
        tx_active_i <= 1'b1;
        cyc(2);
        chk(lamp_pin_o.act, 1'b1);
        repeat (16) begin
            cyc(1);
            if (lamp_pin_o.link === 1'b1) on++;
            else off++;
        end
        chk({on != 0, off != 0}, 2'b11);
        tx_active_i <= 1'b0;
        collision_i <= 1'b0;
        cyc(2);
        chk(lamp_pin_o, 3'b100);
    endtask
    task automatic t_mode3();
        bus(1'b1, OFF_CTRL, 32'h7);
        full_duplex_i <= 1'b1;
        cyc(2);
        chk(lamp_pin_o.act, 1'b1);
        full_duplex_i <= 1'b0;
        cyc(2);
        chk(lamp_pin_o.act, 1'b0);
    endtask
    task automatic t_power();
        pd_req <= 1'b1;
        cyc(3);
        chk(power_down_o, 1'b1);
        pd_req <= 1'b0;
        cyc(3);
        chk(power_down_o, 1'b0);
    endtask
    task automatic t_irq();
        bus(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, OFF_STAT, 32'h0);
        chk(q, 32'h51);
        bus(1'b1, OFF_EVT, 32'hF);
        bus(1'b1, OFF_MASK, 32'h1);
        bus(1'b1, OFF_CTRL, 32'h18);
        chk(sleep_pin_i, 1'b1);
        link_good_i <= 1'b0;
        cyc(3);
        chk({irq_o, sleep_pin_i}, 2'b10);
        bus(1'b1, OFF_EVT, 32'h1);
        cyc(1);
        chk({irq_o, sleep_pin_i}, 2'b01);
        chk({sleep_pin_o, lamp_pin_o.link}, 2'b00);
    endtask
    task automatic t_test_rst();
        test_rst_n_i <= 1'b0;
        #2;
        chk(test_logic_reset_o, 1'b1);
        cyc(1);
        test_rst_n_i <= 1'b1;
        cyc(4);
        chk(test_logic_reset_o, 1'b0);
    endtask

    // main sequence, reset source holds the first reset for 1 us
    initial begin
        t_reset(4'hA, MII_HALF_CYC);
        t_mode1();
        t_mode2();
        t_mode3();
        t_power();
        t_irq();
        t_test_rst();
        strap_lvl <= 3'b010;
        rmii_strap_i <= 1'b1;
        rst_req <= 1'b1;
        cyc(1);
        rst_req <= 1'b0;
        cyc(3);
        bus(1'b0, OFF_CTRL, 32'h0); // held off until initialisation ends
        t_reset(4'h5, RMII_HALF_CYC);
        stop_test();
    end
endmodule
